// *** fcs_regs.vh ***
// register offsets, field positions and status layout of the floppy command and status block
`ifndef FCS_REGS_VH
`define FCS_REGS_VH
`define FCS_ADDR_W        2
`define FCS_OFF_CMD_STAT  2'h0
`define FCS_OFF_HOLD      2'h1
`define FCS_OFF_EXEC      2'h2
`define FCS_OFF_LIVE      2'h3
`define FCS_ST_NOT_READY  7
`define FCS_ST_PROTECT    6
`define FCS_ST_HEAD_FAULT 5
`define FCS_ST_MISSING    4
`define FCS_ST_CRC        3
`define FCS_ST_TRK0_LOST  2
`define FCS_ST_INDEX_REQ  1
`define FCS_ST_BUSY       0
`define FCS_EX_DONE       0
`define FCS_EX_MISSING    1
`define FCS_EX_CRC        2
`define FCS_EX_LOST       3
`define FCS_EX_DELETED    4
`define FCS_EX_WFAULT     5
`define FCS_EX_SEEK_ERR   6
`define FCS_EX_REQ_SET    7
`define FCS_FI_NR2R       0
`define FCS_FI_R2NR       1
`define FCS_FI_INDEX      2
`define FCS_FI_NOW        3
`define FCS_CMD_VERIFY    2
`define FCS_CMD_SETTLE    2
`define FCS_CMD_MARK      0
`define FCS_CMD_TUPD      4
`define FCS_STAT_RESET    8'h00
`endif

// *** fcs_floppy_command_status.v ***
// command decode, acceptance and status reporting of a floppy disk controller
// What this block does
// - data commands sample ready; not ready skips execution and raises completion irq
// - positioning commands execute whatever the ready level
// - each data command refreshes the inner-track output
// - busy holds through execution; completion raises irq and clears busy
// - accepting a non force-interrupt command refreshes status bits and sets busy unless a data command finds the drive not ready
// - force-interrupt while executing leaves other status bits unchanged; busy clears only with no condition or immediate
// - force-interrupt while idle shows positioning-type status; ready or index conditions without immediate set busy
// - holding register read or write clears byte request and its status bit
// - status read clears the completion interrupt
// - positioning commands decoded from bit 7 low, bit 4 is track-update on steps
// - data commands decoded from upper bits; bit 2 settle, bit 0 mark type
// - 1101 in bits 7..4 is force-interrupt with four condition enables
// - conditions: ready rise, ready fall, index, immediate; zero means no irq
// - positioning bit 2 requests track verification on the destination track
// - status bit 7 is not ready ored with master reset
// - positioning status bit 1 inverted index, bit 2 inverted track zero, live
// - read sector status bit 5 reports deleted data mark
// - data status bit 4 flags record missing, cleared on refresh
// - status bit 3 flags crc error, id or data field by record missing
// - data status bit 2 flags lost data, cleared on refresh
// - data status bit 1 mirrors byte request
`include "fcs_regs.vh"
`default_nettype none
module fcs_floppy_command_status (
  // clock and reset
  input  wire        sys_clk_in,
  input  wire        reset_n_in,
  // register port
  input  wire [1:0]  reg_addr_in,
  input  wire [7:0]  reg_wdata_in,
  input  wire        reg_wr_in,
  input  wire        reg_rd_in,
  output reg  [7:0]  reg_rdata_out,
  // drive pins, asynchronous
  input  wire        master_reset_in,
  input  wire        drive_ready_in,
  input  wire        write_lock_in,
  input  wire        track_zero_in,
  input  wire        index_pulse_in,
  input  wire        head_engaged_in,
  input  wire        inner_zone_in,
  // controller outputs
  output reg         byte_request_out,
  output reg         completion_irq_out,
  output reg         busy_out,
  output reg         inner_track_out,
  output reg  [7:0]  command_out,
  output reg         command_start_out
);
  localparam ST_IDLE = 3'b001;
  localparam ST_EXEC = 3'b010;
  localparam ST_WAIT = 3'b100;
  localparam TY_POS  = 2'd0;
  localparam TY_RSEC = 2'd1;
  localparam TY_WR   = 2'd2;
  localparam TY_RD   = 2'd3;

  // command class from the upper nibble
  function [1:0] cmd_type;
    input [7:0] c;
    begin
      if (!c[7])
        cmd_type = TY_POS;
      else if (c[7:5] == 3'b100 || c[7:4] == 4'b1100 || c[7:4] == 4'b1110)
        cmd_type = TY_RD;
      else
        cmd_type = TY_WR;
    end
  endfunction

  reg [6:0] sync1_q;
  reg [6:0] sync2_q;
  reg       ready_prev_q;
  reg       index_prev_q;
  reg [2:0] state_q;
  reg [1:0] type_q;
  reg       read_sector_q;
  reg       track_cmd_q;
  reg [3:0] fi_cond_q;
  reg       irq_q;
  reg       req_q;
  reg       missing_q;
  reg       crc_q;
  reg       lost_q;
  reg       mark_q;
  reg       wfault_q;
  reg       seek_err_q;
  reg       protect_q;
  reg [7:0] holding_reg_q;
  reg [7:0] stat_d;

  wire mr_s    = sync2_q[0];
  wire ready_s = sync2_q[1];
  wire wlock_s = sync2_q[2];
  wire trk0_s  = sync2_q[3];
  wire index_s = sync2_q[4];
  wire head_s  = sync2_q[5];
  wire zone_s  = sync2_q[6];

  wire wr_cmd   = reg_wr_in && reg_addr_in == `FCS_OFF_CMD_STAT;
  wire wr_hold  = reg_wr_in && reg_addr_in == `FCS_OFF_HOLD;
  wire wr_exec  = reg_wr_in && reg_addr_in == `FCS_OFF_EXEC;
  wire rd_stat  = reg_rd_in && reg_addr_in == `FCS_OFF_CMD_STAT;
  wire rd_hold  = reg_rd_in && reg_addr_in == `FCS_OFF_HOLD;
  wire is_fi    = reg_wdata_in[7:4] == 4'b1101;
  wire [1:0] new_type = cmd_type(reg_wdata_in);
  wire busy     = state_q != ST_IDLE;
  wire done_ev  = wr_exec && reg_wdata_in[`FCS_EX_DONE] && state_q == ST_EXEC;
  wire cond_hit = (fi_cond_q[`FCS_FI_NR2R] && ready_s && !ready_prev_q) ||
                  (fi_cond_q[`FCS_FI_R2NR] && !ready_s && ready_prev_q) ||
                  (fi_cond_q[`FCS_FI_INDEX] && index_s && !index_prev_q);

  // two-flop synchronisers on all drive pins
  always @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      sync1_q <= 7'h00;
      sync2_q <= 7'h00;
      ready_prev_q <= 1'b0;
      index_prev_q <= 1'b0;
    end else begin
      sync1_q <= {inner_zone_in, head_engaged_in, index_pulse_in, track_zero_in,
                  write_lock_in, drive_ready_in, master_reset_in};
      sync2_q <= sync1_q;
      ready_prev_q <= ready_s;
      index_prev_q <= index_s;
    end
  end

  // status multiplexed by last accepted command type
  always @* begin
    stat_d = `FCS_STAT_RESET;
    stat_d[`FCS_ST_NOT_READY] = !ready_s || mr_s;
    stat_d[`FCS_ST_BUSY] = busy;
    stat_d[`FCS_ST_CRC] = crc_q;
    case (type_q)
      TY_POS: begin
        stat_d[`FCS_ST_PROTECT] = !wlock_s;
        stat_d[`FCS_ST_HEAD_FAULT] = head_s;
        stat_d[`FCS_ST_MISSING] = seek_err_q;
        stat_d[`FCS_ST_TRK0_LOST] = !trk0_s;
        stat_d[`FCS_ST_INDEX_REQ] = !index_s;
      end
      TY_WR: begin
        stat_d[`FCS_ST_PROTECT] = protect_q;
        stat_d[`FCS_ST_HEAD_FAULT] = wfault_q;
        // whole-track transfers have no record to miss
        stat_d[`FCS_ST_MISSING] = missing_q && !track_cmd_q;
        stat_d[`FCS_ST_TRK0_LOST] = lost_q;
        stat_d[`FCS_ST_INDEX_REQ] = req_q;
      end
      TY_RD: begin
        stat_d[`FCS_ST_HEAD_FAULT] = read_sector_q && mark_q;
        stat_d[`FCS_ST_MISSING] = missing_q && !track_cmd_q;
        stat_d[`FCS_ST_TRK0_LOST] = lost_q;
        stat_d[`FCS_ST_INDEX_REQ] = req_q;
      end
      default: stat_d[`FCS_ST_INDEX_REQ] = 1'b0;
    endcase
  end

  always @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      state_q <= ST_IDLE;
      type_q <= TY_POS;
      read_sector_q <= 1'b0;
      track_cmd_q <= 1'b0;
      fi_cond_q <= 4'h0;
      irq_q <= 1'b0;
      req_q <= 1'b0;
      missing_q <= 1'b0;
      crc_q <= 1'b0;
      lost_q <= 1'b0;
      mark_q <= 1'b0;
      wfault_q <= 1'b0;
      seek_err_q <= 1'b0;
      protect_q <= 1'b0;
      holding_reg_q <= 8'h00;
      inner_track_out <= 1'b0;
      command_out <= 8'h00;
      command_start_out <= 1'b0;
      reg_rdata_out <= 8'h00;
      byte_request_out <= 1'b0;
      completion_irq_out <= 1'b0;
      busy_out <= 1'b0;
    end else begin
      command_start_out <= 1'b0;
      if (rd_stat)
        irq_q <= 1'b0;
      if (rd_hold || wr_hold)
        req_q <= 1'b0;
      if (wr_hold)
        holding_reg_q <= reg_wdata_in;
      // execution engine reports, set wins over clear
      if (wr_exec && busy) begin
        if (reg_wdata_in[`FCS_EX_REQ_SET])
          req_q <= 1'b1;
        if (reg_wdata_in[`FCS_EX_MISSING])
          missing_q <= 1'b1;
        if (reg_wdata_in[`FCS_EX_CRC])
          crc_q <= 1'b1;
        if (reg_wdata_in[`FCS_EX_LOST])
          lost_q <= 1'b1;
        if (reg_wdata_in[`FCS_EX_DELETED])
          mark_q <= 1'b1;
        if (reg_wdata_in[`FCS_EX_WFAULT])
          wfault_q <= 1'b1;
        if (reg_wdata_in[`FCS_EX_SEEK_ERR])
          seek_err_q <= 1'b1;
      end
      if (wr_cmd && is_fi) begin
        fi_cond_q <= reg_wdata_in[3:0];
        state_q <= reg_wdata_in[3:0] == 4'h0 || reg_wdata_in[`FCS_FI_NOW] ? ST_IDLE : ST_WAIT;
        if (reg_wdata_in[`FCS_FI_NOW])
          irq_q <= 1'b1;
        if (state_q != ST_EXEC) begin
          type_q <= TY_POS;
          seek_err_q <= 1'b0;
          crc_q <= 1'b0;
        end
        // an executing command keeps its status; busy drops only with no condition or immediate
      end else if (wr_cmd && !busy) begin
        type_q <= new_type;
        read_sector_q <= reg_wdata_in[7:5] == 3'b100;
        track_cmd_q <= reg_wdata_in[7:5] == 3'b111;
        req_q <= 1'b0;
        missing_q <= 1'b0;
        crc_q <= 1'b0;
        lost_q <= 1'b0;
        mark_q <= 1'b0;
        wfault_q <= 1'b0;
        seek_err_q <= 1'b0;
        protect_q <= new_type == TY_WR && !wlock_s;
        command_out <= reg_wdata_in; // flags: verify, settle, mark, track update
        if (new_type == TY_POS) begin
          state_q <= ST_EXEC;
          command_start_out <= 1'b1;
        end else begin
          inner_track_out <= zone_s;
          if (!ready_s) begin
            state_q <= ST_IDLE;
            irq_q <= 1'b1;
          end else begin
            state_q <= ST_EXEC;
            command_start_out <= 1'b1;
          end
        end
      end else begin
        case (state_q)
          ST_IDLE: state_q <= ST_IDLE;
          ST_EXEC: if (done_ev) begin
            state_q <= ST_IDLE;
            irq_q <= 1'b1;
          end
          ST_WAIT: if (cond_hit) begin
            state_q <= ST_IDLE;
            irq_q <= 1'b1;
          end
          default: state_q <= ST_IDLE;
        endcase
      end
      if (reg_rd_in) begin
        case (reg_addr_in)
          `FCS_OFF_CMD_STAT: reg_rdata_out <= stat_d;
          `FCS_OFF_HOLD:     reg_rdata_out <= holding_reg_q;
          `FCS_OFF_LIVE:     reg_rdata_out <= command_out;
          default:           reg_rdata_out <= 8'h00;
        endcase
      end else
        reg_rdata_out <= 8'h00;
      byte_request_out <= req_q && !(rd_hold || wr_hold);
      completion_irq_out <= irq_q && !rd_stat;
      busy_out <= busy;
    end
  end
endmodule // fcs_floppy_command_status
`default_nettype wire

// *** fcs_host_model.sv ***
// host bus master model for the floppy command and status block
`default_nettype none
module fcs_host_model (
  // clock and read data
  input  wire logic       clk_in,
  input  wire logic [7:0] rdata_in,
  // register port
  output var  logic [1:0] addr_out,
  output var  logic [7:0] wdata_out,
  output var  logic       wr_out,
  output var  logic       rd_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {addr_out, wdata_out, wr_out, rd_out} = '0;
  // callers send commands only while idle, save force-interrupt and the refusal case
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'b1;
    @(posedge clk_in);
    wr_out <= 1'b0;
    wdata_out <= ~d;
    #1;
  endtask
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clk_in);
    rd_out <= 1'b0;
    #1;
    d = rdata_in;
  endtask
endmodule // fcs_host_model
`default_nettype wire

// *** fcs_floppy_command_status_chk.sv ***
// assertions on the ports of the floppy command and status block
`default_nettype none
module fcs_floppy_command_status_chk (
  // clock, reset and register port
  input wire logic       sys_clk_in,
  input wire logic       reset_n_in,
  input wire logic [1:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic       reg_wr_in,
  input wire logic       reg_rd_in,
  // drive and controller lines
  input wire logic       drive_ready_in,
  input wire logic       byte_request_out,
  input wire logic       completion_irq_out,
  input wire logic       busy_out,
  input wire logic [7:0] command_out,
  input wire logic       command_start_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  wire logic cw = reg_wr_in && reg_addr_in == 2'h0;
  wire logic fi = reg_wdata_in[7:4] == 4'hd;
  sequence done_s;
    !busy_out && completion_irq_out;
  endsequence
  start_busy_a: assert property (command_start_out |=> busy_out)
    else $error("start pulse without busy");
  pos_accept_a: assert property (cw && !busy_out && !reg_wdata_in[7] |=> command_start_out ##1 busy_out)
    else $error("positioning command not started");
  not_ready_a: assert property (cw && !busy_out && reg_wdata_in[7] && !fi && !drive_ready_in
    && !$past(drive_ready_in, 2) |=> ##1 done_s)
    else $error("data command ran while not ready");
  refused_a: assert property (cw && busy_out && !fi |=> $stable(command_out))
    else $error("command taken while busy");
  exec_done_a: assert property (busy_out && reg_wr_in && reg_addr_in == 2'h2 && reg_wdata_in[0]
    && command_out[7:4] != 4'hd |=> ##1 done_s)
    else $error("completion not reported");
  fi_now_a: assert property (cw && reg_wdata_in == 8'hd8 |=> ##1 done_s)
    else $error("immediate interrupt missing");
  stat_irq_a: assert property (reg_rd_in && reg_addr_in == 2'h0 |=> !completion_irq_out)
    else $error("status read kept irq");
  hold_req_a: assert property ((reg_rd_in || reg_wr_in) && reg_addr_in == 2'h1 |=> !byte_request_out)
    else $error("holding access kept request");
endmodule // fcs_floppy_command_status_chk
bind fcs_floppy_command_status fcs_floppy_command_status_chk u_chk (.*);
`default_nettype wire

// *** fcs_floppy_command_status_tb_top.sv ***
// testbench of the floppy command and status block
`default_nettype none
module fcs_floppy_command_status_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       sys_clk_in = 1'b0, reset_n_in = 1'b0, master_reset_in = 1'b0, drive_ready_in = 1'b1;
  logic       write_lock_in = 1'b1, track_zero_in = 1'b0, index_pulse_in = 1'b1;
  logic       head_engaged_in = 1'b1, inner_zone_in = 1'b1;
  logic       reg_wr_in, reg_rd_in, byte_request_out, completion_irq_out, busy_out, inner_track_out;
  logic       command_start_out;
  logic [1:0] reg_addr_in;
  logic [7:0] reg_wdata_in, reg_rdata_out, command_out, st;
  logic [7:0] cmds [5] = '{8'h80, 8'ha0, 8'hc0, 8'he0, 8'hf0};
  int         error_cnt = 0;
  int         num_checks = 0;
  always #4 sys_clk_in = ~sys_clk_in;
  fcs_floppy_command_status dut (.*);
  fcs_host_model h (.clk_in(sys_clk_in), .rdata_in(reg_rdata_out), .addr_out(reg_addr_in),
    .wdata_out(reg_wdata_in), .wr_out(reg_wr_in), .rd_out(reg_rd_in));
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  // drive pins pass a two-flop synchroniser, so wait past it
  task automatic pins(input logic r, input logic z, input logic x);
    @(posedge sys_clk_in);
    drive_ready_in <= r;
    inner_zone_in <= z;
    index_pulse_in <= x;
    repeat (5) @(posedge sys_clk_in);
  endtask
  // flags are registered copies of internal state, one edge behind it
  task automatic tick;
    @(posedge sys_clk_in);
    #1;
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk_in);
    error_cnt++;
    test_done;
  end
  initial begin
    repeat (3) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    pins(1'b1, 1'b1, 1'b1);
    for (int i = 0; i < 8; i++) begin
      h.wr(2'h0, {i[3:0], 4'h0});
      chk(command_out, {i[3:0], 4'h0});
      h.wr(2'h0, 8'hd0);
      tick();
      chk(busy_out, 8'h00);
    end
    h.wr(2'h0, 8'h00);
    h.rd(2'h0, st);
    chk(st & 8'h87, 8'h05);
    h.wr(2'h0, 8'h80);
    chk(command_out, 8'h00);
    h.wr(2'h2, 8'h01);
    tick();
    chk(completion_irq_out, 8'h01);
    h.rd(2'h0, st);
    chk({completion_irq_out, st[0]}, 8'h00);
    $display("test positioning done");
    for (int i = 0; i < 5; i++) begin
      pins(1'b1, i[0], 1'b1);
      h.wr(2'h0, cmds[i]);
      chk(inner_track_out, i[0]);
      h.wr(2'h2, 8'h80);
      h.rd(2'h0, st);
      chk(st & 8'h1f, 8'h03);
      chk(byte_request_out, 8'h01);
      h.rd(2'h1, st);
      chk(byte_request_out, 8'h00);
      h.wr(2'h2, 8'h80);
      h.wr(2'h1, 8'h5a);
      chk(byte_request_out, 8'h00);
      h.wr(2'h2, 8'h13);
      h.rd(2'h0, st);
      chk(st & 8'h31, {2'b00, i == 0, i < 3, 4'h0});
    end
    h.wr(2'h0, 8'hd0);
    h.rd(2'h0, st);
    chk(st & 8'h07, 8'h04);
    $display("test data done");
    pins(1'b0, 1'b1, 1'b1);
    h.wr(2'h0, 8'h80);
    tick();
    chk({busy_out, completion_irq_out, inner_track_out}, 8'h03);
    h.rd(2'h0, st);
    chk(st[7], 8'h01);
    h.wr(2'h0, 8'h20);
    tick();
    chk(busy_out, 8'h01);
    h.wr(2'h0, 8'hd8);
    tick();
    chk({busy_out, completion_irq_out}, 8'h01);
    pins(1'b0, 1'b0, 1'b0);
    h.rd(2'h0, st);
    chk(st[1], 8'h01);
    h.wr(2'h0, 8'hd1);
    tick();
    chk({busy_out, completion_irq_out}, 8'h02);
    pins(1'b1, 1'b0, 1'b0);
    chk({busy_out, completion_irq_out}, 8'h01);
    $display("test ready done");
    test_done;
  end
endmodule // fcs_floppy_command_status_tb_top
`default_nettype wire
